/* File: core/ecei_pkg.sv */
// Package for the encoder, compare and error I/O block.
// Assumes a single 100 MHz controller clock.
package ecei_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 10000;
  localparam int unsigned TRIG_PULSE_NS    = 510;
  localparam int unsigned TRIG_PULSE_CYC   = (TRIG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned POS_W            = 32;
  localparam int unsigned PULSE_CNT_W      = 8;
  localparam logic [7:0]  GPIN_FIRST_NUM   = 8'h51; // General input 81
  localparam logic [7:0]  GPIN_SECOND_NUM  = 8'h52; // General input 82
  localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(TRIG_PULSE_CYC);
  // Register map
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_POS      = 4'h1;
  localparam logic [3:0]  ADDR_CMP_POS  = 4'h2;
  localparam logic [3:0]  ADDR_CMP_INC  = 4'h3;
  localparam logic [3:0]  ADDR_ERR_LIM  = 4'h4;
  localparam logic [3:0]  ADDR_POS_ERR  = 4'h5;
  localparam logic [3:0]  ADDR_GPIN     = 4'h6;
  localparam logic [3:0]  ADDR_ARM      = 4'h7;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h9;
  localparam logic [3:0]  ADDR_STATUS   = 4'hA;
  // Control bit positions
  localparam int unsigned CTRL_PULSE_DIR = 0;
  localparam int unsigned CTRL_STEPPER   = 1;
  localparam int unsigned CTRL_SERIAL    = 2;
  localparam int unsigned CTRL_CMP_INC   = 3;
  localparam int unsigned CTRL_STEP_LVL  = 4;
  localparam int unsigned CTRL_DIR_LVL   = 5;
  localparam int unsigned CTRL_LEAD_CLK  = 6;
  localparam int unsigned CTRL_EXTRA_CLK = 7;
  localparam int unsigned CTRL_CPU_RST   = 8;
  localparam int unsigned CTRL_W         = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  // Interrupt bits
  localparam int unsigned IRQ_TRIG   = 0;
  localparam int unsigned IRQ_ERR    = 1;
  localparam int unsigned IRQ_W      = 2;
  typedef enum logic [1:0] {ECEI_QUAD_IDLE, ECEI_QUAD_RUN} ecei_unused_t;
endpackage

/* File: core/ecei_sync.sv */
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes the destination clock is core_clk.
`timescale 1ns/1ps
`default_nettype none
module ecei_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff; // First stage, read only by second stage

  // Two stages per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          meta_ff[gi]  <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else
        begin
          meta_ff[gi]  <= async_in[gi];
          sync_out[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: core/ecei_top.sv */
// Encoder decode, shared pin routing, position compare and fault output.
// Assumes a 100 MHz core_clk and a simple strobe register port.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - Quadrature or pulse/direction decode, quadrature default
// R2 - Pulse on first phase, direction second
// R3 - Extra phases readable as inputs 81, 82
// R4 - Stepper mode disables extra encoder inputs
// R5 - Serial: pins 1,2 lead, 3,4 extra
// R6 - Serial data in pins 1,3; clock 2,4
// R7 - Stepper: step pin two, direction pin four
// R8 - Compare uses lead encoder position count
// R9 - Incremental compare: 510 ns low pulse
// R10 - One-shot compare holds low until rearmed
// R11 - Any error drives fault low, lamp on
// R12 - Error when position error exceeds limit
// R13 - Error while reset input held low
// R14 - Error during processor self reset
// R15 - Count quadrature up to 15 MHz
// R16 - Quadrature counts every edge, synchronised inputs
module ecei_top
  import ecei_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // Encoder pins
  input  wire logic                  lead_encoder_first_phase,
  input  wire logic                  lead_encoder_second_phase,
  input  wire logic                  extra_encoder_first_phase,
  input  wire logic                  extra_encoder_second_phase,
  // Shared pins, three signals each
  input  wire logic                  shared_pin_one_in,
  output var  logic                  shared_pin_one_out,
  output var  logic                  shared_pin_one_oe,
  input  wire logic                  shared_pin_two_in,
  output var  logic                  shared_pin_two_out,
  output var  logic                  shared_pin_two_oe,
  input  wire logic                  shared_pin_three_in,
  output var  logic                  shared_pin_three_out,
  output var  logic                  shared_pin_three_oe,
  input  wire logic                  shared_pin_four_in,
  output var  logic                  shared_pin_four_out,
  output var  logic                  shared_pin_four_oe,
  // Serial encoder data to the controller
  output var  logic                  lead_serial_data,
  output var  logic                  extra_serial_data,
  // Compare and fault outputs
  output var  logic                  position_trigger_out_n,
  output var  logic                  fault_out_n,
  output var  logic                  error_lamp,
  output var  logic                  irq,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [POS_W-1:0]      reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [POS_W-1:0]      reg_rdata
);
  import ecei_pkg::*;

  logic [3:0]             pin_sync;       // Synchronised encoder phases
  logic [3:0]             pin_prev_ff;    // Previous synchronised phases
  logic [CTRL_W-1:0]      ctrl_ff;        // Control register
  logic [POS_W-1:0]       pos_ff;         // Lead position count
  logic [POS_W-1:0]       nxt_pos;        // Next position
  logic [POS_W-1:0]       cmp_pos_ff;     // One-shot target
  logic [POS_W-1:0]       cmp_inc_ff;     // Incremental step
  logic [POS_W-1:0]       cmp_next_ff;    // Next incremental mark
  logic [POS_W-1:0]       err_lim_ff;     // Position error limit
  logic [POS_W-1:0]       pos_err_ff;     // Signed axis position error
  logic                   armed_ff;       // Compare armed
  logic                   start_side_ff;  // Position below target at arm
  logic [PULSE_CNT_W-1:0] pulse_cnt_ff;   // Pulse width counter
  logic                   trig_event;     // Compare fired this cycle
  logic                   oneshot_ff;     // One-shot output held low
  logic                   err_cond;       // Any error
  logic [IRQ_W-1:0]       irq_stat_ff;    // Sticky events
  logic [IRQ_W-1:0]       irq_mask_ff;    // Interrupt enables
  logic                   err_prev_ff;    // Error edge detect
  logic                   stat_rd;        // Interrupt status read clears
  logic [POS_W-1:0]       abs_err;        // Error magnitude
  logic                   quad_step;      // Quadrature count edge
  logic                   quad_up;        // Quadrature direction
  logic                   pd_step;        // Pulse/direction edge
  logic                   extra_en;       // Extra encoder usable

  // Pin synchronisers, two stages; keeps 15 MHz edges at 100 MHz
  ecei_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({extra_encoder_second_phase, extra_encoder_first_phase,
                lead_encoder_second_phase, lead_encoder_first_phase}),
    .sync_out (pin_sync)
  ); // R15 R16

  // Previous phase samples
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_prev_ff <= 4'h0;
    else
      pin_prev_ff <= pin_sync;
  end

  // Quadrature: an edge on one phase alone counts, direction from phase order
  always_comb
  begin
    quad_step = (pin_sync[0] ^ pin_prev_ff[0]) ^ (pin_sync[1] ^ pin_prev_ff[1]); // R16
    quad_up   = pin_prev_ff[0] ^ pin_sync[1]; // R16
  end

  // Pulse/direction: rising edge of first phase counts
  assign pd_step = pin_sync[0] & ~pin_prev_ff[0]; // R2

  // Next position by decode mode
  always_comb
  begin
    nxt_pos = pos_ff;
    if (ctrl_ff[CTRL_PULSE_DIR]) // R1
    begin
      if (pd_step)
        nxt_pos = pin_sync[1] ? pos_ff - 1'b1 : pos_ff + 1'b1; // R2
    end
    else if (quad_step)
    begin
      nxt_pos = quad_up ? pos_ff + 1'b1 : pos_ff - 1'b1; // R16
    end
  end

  // Extra encoder only usable outside stepper mode
  assign extra_en = ~ctrl_ff[CTRL_STEPPER]; // R4

  // Stat read strobe
  assign stat_rd = reg_rd && (reg_addr == ADDR_IRQ_STAT);

  // Register writes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_ff     <= CTRL_RESET; // R1
      cmp_pos_ff  <= '0;
      cmp_inc_ff  <= '0;
      err_lim_ff  <= '1;
      pos_err_ff  <= '0;
      irq_mask_ff <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CTRL:     ctrl_ff     <= reg_wdata[CTRL_W-1:0];
        ADDR_CMP_POS:  cmp_pos_ff  <= reg_wdata;
        ADDR_CMP_INC:  cmp_inc_ff  <= reg_wdata;
        ADDR_ERR_LIM:  err_lim_ff  <= reg_wdata;
        ADDR_POS_ERR:  pos_err_ff  <= reg_wdata;
        ADDR_IRQ_MASK: irq_mask_ff <= reg_wdata[IRQ_W-1:0];
        default:       ;
      endcase
    end
  end

  // Position counter, also preset by software
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pos_ff <= '0;
    else if (reg_wr && reg_addr == ADDR_POS)
      pos_ff <= reg_wdata;
    else
      pos_ff <= nxt_pos;
  end

  // Compare arm and fire, from the lead count
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      armed_ff      <= 1'b0;
      start_side_ff <= 1'b0;
      cmp_next_ff   <= '0;
      oneshot_ff    <= 1'b0;
      trig_event    <= 1'b0;
    end
    else
    begin
      trig_event <= 1'b0;
      if (reg_wr && reg_addr == ADDR_ARM)
      begin
        // Rearm releases the one-shot level
        armed_ff      <= 1'b1;
        oneshot_ff    <= 1'b0; // R10
        start_side_ff <= $signed(pos_ff) < $signed(cmp_pos_ff);
        cmp_next_ff   <= pos_ff + cmp_inc_ff;
      end
      else if (armed_ff && ctrl_ff[CTRL_CMP_INC])
      begin
        // Each advance by the increment fires
        if (cmp_inc_ff != '0 && pos_ff == cmp_next_ff) // R8
        begin
          trig_event  <= 1'b1; // R9
          cmp_next_ff <= cmp_next_ff + cmp_inc_ff;
        end
      end
      else if (armed_ff)
      begin
        // Fire once the target is passed in either direction
        if (start_side_ff ? ($signed(pos_ff) >= $signed(cmp_pos_ff))
                          : ($signed(pos_ff) <= $signed(cmp_pos_ff))) // R8
        begin
          oneshot_ff <= 1'b1; // R10
          armed_ff   <= 1'b0;
          trig_event <= 1'b1;
        end
      end
    end
  end

  // Low pulse width counter
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt_ff <= '0;
    else if (trig_event && ctrl_ff[CTRL_CMP_INC])
      pulse_cnt_ff <= PULSE_LOAD; // R9
    else if (pulse_cnt_ff != '0)
      pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
  end

  // Trigger output, low for pulse or held one-shot
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      position_trigger_out_n <= 1'b1;
    else
      position_trigger_out_n <= ~((pulse_cnt_ff != '0) | oneshot_ff); // R9 R10
  end

  // Error magnitude against limit
  always_comb
  begin
    abs_err  = pos_err_ff[POS_W-1] ? (~pos_err_ff + 1'b1) : pos_err_ff;
    err_cond = (abs_err > err_lim_ff) | ctrl_ff[CTRL_CPU_RST]; // R12 R14
  end

  // Fault output; reset value itself signals error
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_out_n <= 1'b0; // R13
      error_lamp  <= 1'b1; // R13
    end
    else
    begin
      fault_out_n <= ~err_cond; // R11
      error_lamp  <= err_cond;  // R11
    end
  end

  // Sticky events; set wins over read clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_ff <= '0;
      err_prev_ff <= 1'b0;
    end
    else
    begin
      err_prev_ff <= err_cond;
      irq_stat_ff <= (stat_rd ? '0 : irq_stat_ff)
                   | {err_cond & ~err_prev_ff, trig_event};
    end
  end

  // Interrupt level
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_ff & irq_mask_ff);
  end

  // Shared pin routing by mode
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shared_pin_one_out   <= 1'b0;
      shared_pin_one_oe    <= 1'b0;
      shared_pin_two_out   <= 1'b0;
      shared_pin_two_oe    <= 1'b0;
      shared_pin_three_out <= 1'b0;
      shared_pin_three_oe  <= 1'b0;
      shared_pin_four_out  <= 1'b0;
      shared_pin_four_oe   <= 1'b0;
      lead_serial_data     <= 1'b0;
      extra_serial_data    <= 1'b0;
    end
    else
    begin
      // Pins one and three never driven
      shared_pin_one_out   <= 1'b0; // R7
      shared_pin_one_oe    <= 1'b0;
      shared_pin_three_out <= 1'b0;
      shared_pin_three_oe  <= 1'b0;
      if (ctrl_ff[CTRL_STEPPER])
      begin
        // Step on two, direction on four
        shared_pin_two_out  <= ctrl_ff[CTRL_STEP_LVL]; // R7
        shared_pin_two_oe   <= 1'b1;
        shared_pin_four_out <= ctrl_ff[CTRL_DIR_LVL];  // R7
        shared_pin_four_oe  <= 1'b1;
        lead_serial_data    <= 1'b0;
        extra_serial_data   <= 1'b0;
      end
      else if (ctrl_ff[CTRL_SERIAL])
      begin
        // Data in on one/three, clocks out on two/four
        shared_pin_two_out  <= ctrl_ff[CTRL_LEAD_CLK];  // R5 R6
        shared_pin_two_oe   <= 1'b1;
        shared_pin_four_out <= ctrl_ff[CTRL_EXTRA_CLK]; // R5 R6
        shared_pin_four_oe  <= 1'b1;
        lead_serial_data    <= shared_pin_one_in;   // R6
        extra_serial_data   <= shared_pin_three_in; // R6
      end
      else
      begin
        // Unused
        shared_pin_two_out  <= 1'b0;
        shared_pin_two_oe   <= 1'b0;
        shared_pin_four_out <= 1'b0;
        shared_pin_four_oe  <= 1'b0;
        lead_serial_data    <= 1'b0;
        extra_serial_data   <= 1'b0;
      end
    end
  end

  // Read port, data one cycle later
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL:     reg_rdata <= POS_W'(ctrl_ff);
        ADDR_POS:      reg_rdata <= pos_ff;
        ADDR_CMP_POS:  reg_rdata <= cmp_pos_ff;
        ADDR_CMP_INC:  reg_rdata <= cmp_inc_ff;
        ADDR_ERR_LIM:  reg_rdata <= err_lim_ff;
        ADDR_POS_ERR:  reg_rdata <= pos_err_ff;
        // Inputs 81 and 82 in bits 0/1, zero in stepper mode
        ADDR_GPIN:     reg_rdata <= POS_W'({pin_sync[3] & extra_en,
                                            pin_sync[2] & extra_en}); // R3 R4
        ADDR_IRQ_STAT: reg_rdata <= POS_W'(irq_stat_ff);
        ADDR_IRQ_MASK: reg_rdata <= POS_W'(irq_mask_ff);
        ADDR_STATUS:   reg_rdata <= POS_W'({armed_ff, oneshot_ff, err_cond});
        default:       reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end
endmodule
`default_nettype wire

/* File: tb/ecei_chk.sv */
// Port checker for the encoder, compare and error block.
// Mirrors register writes; sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module ecei_chk
  import ecei_pkg::*;
(
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             reset_n,
  // Shared pins
  input wire logic             shared_pin_one_in,
  input wire logic             shared_pin_three_in,
  input wire logic             shared_pin_one_oe,
  input wire logic             shared_pin_two_oe,
  input wire logic             shared_pin_three_oe,
  input wire logic             shared_pin_four_oe,
  input wire logic             shared_pin_two_out,
  input wire logic             shared_pin_four_out,
  // Outputs under watch
  input wire logic             lead_serial_data,
  input wire logic             extra_serial_data,
  input wire logic             position_trigger_out_n,
  input wire logic             fault_out_n,
  input wire logic             error_lamp,
  // Register port
  input wire logic [3:0]       reg_addr,
  input wire logic [POS_W-1:0] reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [POS_W-1:0] reg_rdata
);
  logic [CTRL_W-1:0] ctrl_ff; // Control word copy
  logic [POS_W-1:0]  lim_ff;  // Error limit copy
  logic [POS_W-1:0]  perr_ff; // Position error copy
  logic [7:0]        low_ff;  // Trigger low run length
  logic              up_ff;   // Past first edge after reset
  logic              arm_wr;  // Arm write in this cycle
  logic              err_c;   // Error condition now
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Copy of the software-written state
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      ctrl_ff <= CTRL_RESET;
      lim_ff  <= '1;
      perr_ff <= '0;
      up_ff   <= 1'b0;
    end
    else
    begin
      up_ff <= 1'b1;
      if (reg_wr && reg_addr == ADDR_CTRL) ctrl_ff <= reg_wdata[CTRL_W-1:0];
      if (reg_wr && reg_addr == ADDR_ERR_LIM) lim_ff <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_POS_ERR) perr_ff <= reg_wdata;
    end
  // Length of the current low run of the trigger
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) low_ff <= 8'h00;
    else low_ff <= position_trigger_out_n ? 8'h00 : low_ff + 8'h01;
  assign arm_wr = reg_wr && reg_addr == ADDR_ARM;
  assign err_c  = ctrl_ff[CTRL_CPU_RST] || ((perr_ff[POS_W-1] ? -perr_ff : perr_ff) > lim_ff);
  // Mode settled for at least one edge
  sequence s_step_mode;
    $stable(ctrl_ff) && ctrl_ff[CTRL_STEPPER];
  endsequence
  sequence s_ser_mode;
    $stable(ctrl_ff) && ctrl_ff[CTRL_SERIAL] && !ctrl_ff[CTRL_STEPPER];
  endsequence
  // One-shot low with no rearm in sight
  sequence s_held;
    !ctrl_ff[CTRL_CMP_INC] && !$past(ctrl_ff[CTRL_CMP_INC]) && !position_trigger_out_n
      && !arm_wr && !$past(arm_wr);
  endsequence
  a_gpin_stepper: assert property (
    ($past(reg_rd) && $past(reg_addr) == ADDR_GPIN && ctrl_ff[CTRL_STEPPER]
      && $past(ctrl_ff[CTRL_STEPPER])) |-> reg_rdata == '0)
    else $error("general inputs not blank in stepper mode");
  a_lamp_pair: assert property (fault_out_n != error_lamp)
    else $error("lamp and fault output disagree");
  a_reset_err: assert property (disable iff (1'b0) !reset_n |-> !fault_out_n && error_lamp)
    else $error("no error shown during reset");
  a_err_follow: assert property (up_ff |-> fault_out_n == !$past(err_c))
    else $error("fault output does not follow error condition");
  a_pulse_width: assert property (
    (ctrl_ff[CTRL_CMP_INC] && $rose(position_trigger_out_n)) |-> low_ff == PULSE_LOAD)
    else $error("incremental trigger pulse width wrong");
  a_oneshot_hold: assert property (s_held |=> !position_trigger_out_n)
    else $error("one-shot trigger released without rearm");
  a_step_pins: assert property (s_step_mode |-> shared_pin_two_oe && shared_pin_four_oe
    && !shared_pin_one_oe && !shared_pin_three_oe
    && shared_pin_two_out == ctrl_ff[CTRL_STEP_LVL] && shared_pin_four_out == ctrl_ff[CTRL_DIR_LVL])
    else $error("stepper pin routing wrong");
  a_serial_pins: assert property (s_ser_mode |-> shared_pin_two_oe && shared_pin_four_oe
    && !shared_pin_one_oe && !shared_pin_three_oe && shared_pin_two_out == ctrl_ff[CTRL_LEAD_CLK]
    && shared_pin_four_out == ctrl_ff[CTRL_EXTRA_CLK])
    else $error("serial pin routing wrong");
  a_serial_data: assert property (s_ser_mode |-> lead_serial_data == $past(shared_pin_one_in)
    && extra_serial_data == $past(shared_pin_three_in))
    else $error("serial data not taken from pins one and three");
endmodule
bind ecei_top ecei_chk u_chk (.core_clk, .reset_n, .shared_pin_one_in, .shared_pin_three_in,
  .shared_pin_one_oe, .shared_pin_two_oe, .shared_pin_three_oe, .shared_pin_four_oe,
  .shared_pin_two_out, .shared_pin_four_out, .lead_serial_data, .extra_serial_data,
  .position_trigger_out_n, .fault_out_n, .error_lamp, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata);
`default_nettype wire

/* File: tb/ecei_enc_model.sv */
// Far-side model: lead encoder stepping toward a target count.
// Free-running edge grid near 15 MHz quadrature, not tied to the clock.
`timescale 1ns/1ps
`default_nettype none
module ecei_enc_model (
  // Pattern timing
  input  wire logic core_clk,
  // Command
  input  wire logic pd_mode,
  input  var  int   target,
  // Phases and progress
  output var  logic phase_a,
  output var  logic phase_b,
  output var  int   moves,
  // Level on pins nobody drives
  output var  logic pat
);
  logic [1:0] idx  = 2'b00; // Quadrature state
  logic [1:0] ph   = 2'b00; // Pulse sub-step
  logic       pa   = 1'b0;  // Pulse level
  logic       pd_b = 1'b0;  // Direction level, high is down
  initial moves = 0;
  initial pat = 1'b0;
  // Released pins change every cycle so no stale value survives
  always @(negedge core_clk) pat <= ~pat;
  // One edge each 16.7 ns, second phase leads when counting up
  always
  begin
    #16.7;
    if (moves != target && !pd_mode)
    begin
      idx = (target > moves) ? idx + 2'b01 : idx - 2'b01;
      moves = (target > moves) ? moves + 1 : moves - 1;
    end
    else if (moves != target)
    begin
      ph = ph + 2'b01;
      if (ph == 2'b01) pd_b = (target < moves);
      if (ph == 2'b10) pa = 1'b1;
      if (ph == 2'b11)
      begin
        pa = 1'b0;
        moves = pd_b ? moves - 1 : moves + 1;
        ph = 2'b00;
      end
    end
  end
  assign phase_a = pd_mode ? pa : idx[1];
  assign phase_b = pd_mode ? pd_b : idx[0] ^ idx[1];
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the encoder, compare and error block.
// Drives the register port and pins; the encoder model is the far side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecei_pkg::*;
  logic             core_clk  = 1'b0;  // 100 MHz
  logic             reset_n   = 1'b1;  // Async reset
  logic [1:0]       xph       = 2'b00; // Extra encoder phases
  logic [3:0]       reg_addr  = 4'h0;  // Register port
  logic [POS_W-1:0] reg_wdata = '0;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic [POS_W-1:0] reg_rdata;
  logic [POS_W-1:0] rd_v;              // Last read value
  logic             ea, eb, pat, trig_n, fault_n, lamp, irq, lsd, esd;
  logic [3:0]       p_in, p_out, p_oe; // Shared pins, bit 0 is pin one
  logic             pd_mode   = 1'b0;
  logic [8:0]       d, pm [4] = '{9'h044, 9'h084, 9'h012, 9'h026};
  logic [31:0]      pe [4] = '{32'hB, 32'hFFFFFFF5, 32'hA, 32'hFFFFFFF6};
  int               target    = 0;
  int               moves, base, n;
  int               error_cnt = 0;
  int               checked   = 0;
  always #5 core_clk = ~core_clk;
  // Wire level: design drive when enabled, else far-side pattern
  assign p_in = (p_oe & p_out) | (~p_oe & {4{pat}});
  ecei_enc_model u_enc (.core_clk, .pd_mode, .target, .phase_a(ea), .phase_b(eb), .moves, .pat);
  ecei_top DUT (.core_clk, .reset_n, .lead_encoder_first_phase(ea),
    .lead_encoder_second_phase(eb), .extra_encoder_first_phase(xph[0]),
    .extra_encoder_second_phase(xph[1]), .shared_pin_one_in(p_in[0]),
    .shared_pin_one_out(p_out[0]), .shared_pin_one_oe(p_oe[0]), .shared_pin_two_in(p_in[1]),
    .shared_pin_two_out(p_out[1]), .shared_pin_two_oe(p_oe[1]), .shared_pin_three_in(p_in[2]),
    .shared_pin_three_out(p_out[2]), .shared_pin_three_oe(p_oe[2]), .shared_pin_four_in(p_in[3]),
    .shared_pin_four_out(p_out[3]), .shared_pin_four_oe(p_oe[3]), .lead_serial_data(lsd),
    .extra_serial_data(esd), .position_trigger_out_n(trig_n), .fault_out_n(fault_n),
    .error_lamp(lamp), .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bound ran out: count it and stop
  task automatic tmo(input logic hit);
    if (hit)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the next cycle
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  // Encoder moves to a count, bounded
  task automatic go(input int t);
    target = t;
    n = 0;
    while (moves != t && n < 1000)
    begin
      cyc(1);
      n++;
    end
    tmo(n >= 1000);
  endtask
  // Wait for a trigger level; n is the cycles it took
  task automatic wt(input logic lvl);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end while (trig_n !== lvl && n < 300);
    tmo(n >= 300);
  endtask
  initial
  begin
    #2 reset_n = 1'b0;
    cyc(20);
    chk("fault in reset", {fault_n, lamp}, 2'b01);
    @(posedge core_clk) reset_n <= 1'b1;
    cyc(3);
    chk("fault after reset", {fault_n, lamp}, 2'b10);
    rd(4'hF);
    chk("unmapped read", rd_v, 32'h0);
    // Quadrature by default, up then below zero
    base = moves;
    wr(ADDR_POS, 32'h0);
    go(base + 37);
    go(base - 3);
    cyc(5);
    rd(ADDR_POS);
    chk("quad count", rd_v, 32'hFFFFFFFD);
    for (int i = 1; i < 4; i++)
    begin
      @(posedge core_clk) xph <= i[1:0];
      cyc(5);
      rd(ADDR_GPIN);
      chk("general inputs", rd_v, i);
    end
    // Incremental compare, step of four
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h8);
    wr(ADDR_CMP_INC, 32'h4);
    base = moves;
    wr(ADDR_POS, 32'h0);
    wr(ADDR_ARM, 32'h0);
    cyc(60);
    go(base + 4);
    wt(1'b0);
    wt(1'b1);
    chk("pulse cycles", n, TRIG_PULSE_CYC);
    go(base + 8);
    wt(1'b0);
    wt(1'b1);
    chk("second pulse", n, TRIG_PULSE_CYC);
    chk("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq raised", irq, 1'b1);
    rd(ADDR_IRQ_STAT);
    chk("irq status", rd_v, 32'h1);
    cyc(2);
    chk("irq cleared", irq, 1'b0);
    // One-shot at ten, held until rearmed
    wr(ADDR_CTRL, 32'h0);
    base = moves;
    wr(ADDR_POS, 32'h0);
    wr(ADDR_CMP_POS, 32'hA);
    wr(ADDR_ARM, 32'h0);
    cyc(5);
    chk("armed idle", trig_n, 1'b1);
    go(base + 12);
    wt(1'b0);
    cyc(80);
    chk("one-shot held", trig_n, 1'b0);
    rd(ADDR_STATUS);
    chk("status", rd_v, 32'h2);
    wr(ADDR_ARM, 32'h0);
    cyc(3);
    chk("rearm releases", trig_n, 1'b1);
    // Pin routing table, stepper wins over serial
    foreach (pm[k])
    begin
      d = pm[k];
      wr(ADDR_CTRL, {23'h0, d});
      cyc(3);
      chk("pins", {p_oe, p_out[3], p_out[1]},
        {4'b1010, d[1] ? d[5] : d[7], d[1] ? d[4] : d[6]});
    end
    rd(ADDR_GPIN);
    chk("inputs in stepper", rd_v, 32'h0);
    // Error limit at ten, both signs and the boundary
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_ERR_LIM, 32'hA);
    foreach (pe[k])
    begin
      wr(ADDR_POS_ERR, pe[k]);
      cyc(2);
      chk("fault", {fault_n, lamp}, (k < 2) ? 2'b01 : 2'b10);
    end
    wr(ADDR_CTRL, 32'h100);
    cyc(2);
    chk("self reset fault", {fault_n, lamp}, 2'b01);
    // Pulse and direction decode
    wr(ADDR_CTRL, 32'h1);
    @(posedge core_clk) pd_mode <= 1'b1;
    cyc(5);
    base = moves;
    wr(ADDR_POS, 32'h0);
    go(base + 9);
    go(base + 4);
    cyc(5);
    rd(ADDR_POS);
    chk("pulse count", rd_v, 32'h4);
    give_verdict();
  end
endmodule
`default_nettype wire
